// [ssr_defs.svh]
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// register byte offsets on the bus
`define SSR_CMD_OFS 8'h00
`define SSR_CFG_OFS 8'h04
`define SSR_DIV_OFS 8'h08
`define SSR_STAT_OFS 8'h0c
`define SSR_SIZE_OFS 8'h10

// configuration field positions and reset values
`define SSR_CFG_FMT_LSB 0
`define SSR_CFG_SLOT_LSB 4
`define SSR_CFG_RST 2'h2
`define SSR_DIV_RST 16'h0001

// command codes
`define SSR_CMD_FIRST 16'h0001
`define SSR_CMD_NEXT 16'h0002
`define SSR_CMD_CLEAR 16'h0003
`define SSR_CMD_ADD_NET 16'h0029
`define SSR_CMD_ADD_RATE 16'h002e

// value-kind indications
`define SSR_IND_NET 5'h01
`define SSR_IND_RATE 5'h06
`define SSR_IND_SETUP 5'h1e

// 16-bit signed integer limits
`define SSR_INT_MAX 32'sh00007fff
`define SSR_INT_MIN (-32'sh00008000)

// bytes per message slot, and the float-out overhead per message
`define SSR_INT_SLOT_BYTES 8'h04
`define SSR_FLT_IN_SLOT_BYTES 8'h08
`define SSR_FLT_OUT_OVH_BYTES 8'h02
`define SSR_FLT_OUT_SLOT_BYTES 8'h06

// refresh period
`define SSR_UPDATE_MS 60
`define SSR_CLK_KHZ 125000
`define SSR_UPDATE_CYC (`SSR_UPDATE_MS * `SSR_CLK_KHZ)

// rotation and buffer sizes
`define SSR_ROT_DEPTH 4
`define SSR_FIFO_DEPTH 16

`endif

// [ssr_fifo.sv]
`timescale 1ns/1ns
module ssr_fifo
    import ssr_pkg::*;
#(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ssr_fifo_s;

    ssr_fifo_s s;
    ssr_fifo_s next_s;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = (s.wp == s.rp);
    assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = s.mem[s.rp[AW-1:0]];

    // push and pop may share a cycle
    always_comb begin
        next_s = s;
        if (in_valid_i && !full) begin
            next_s.mem[s.wp[AW-1:0]] = in_data_i;
            next_s.wp = s.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// [ssr_pkg.sv]
package ssr_pkg;

    typedef enum logic [1:0] {
        SSR_FMT_INT,
        SSR_FMT_DIV,
        SSR_FMT_FLT
    } ssr_fmt_e;

    typedef enum logic [1:0] {
        SSR_EM_IDLE,
        SSR_EM_DIV,
        SSR_EM_SEND
    } ssr_emit_e;

    // one 16-bit word toward the controller, last marks end of message
    typedef struct packed {
        logic last;
        logic [15:0] data;
    } ssr_word_s;

    // whole state of the rotation block
    typedef struct packed {
        logic [22:0] tick;
        logic [15:0] cmd_word;
        logic [15:0] cmd_last;
        ssr_fmt_e fmt;
        logic [1:0] slots;
        logic [15:0] div_size;
        logic [1:0] ack;
        logic [4:0] ind;
        logic [3:0] rot;
        logic [2:0] len;
        logic [1:0] ptr;
        logic started;
        ssr_emit_e emit;
        logic [1:0] word;
        logic [1:0] slot;
        logic [31:0] val;
        logic [31:0] quot;
        logic [16:0] rem;
        logic [5:0] dcnt;
        logic neg;
        logic [15:0] skipped;
        logic wb_ack;
        logic [31:0] wb_dat;
    } ssr_state_s;

endpackage

// [ssr_plc_model.sv]
`timescale 1ns/1ns
module ssr_plc_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // message stream, one 16-bit word per pop
    input wire logic msg_valid_i,
    input wire logic stall_i,
    output logic msg_ready_o
);
    logic [7:0] lf;

    // irregular ready so the design meets both prompt and slow takers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lf <= 8'h5a;
            msg_ready_o <= 1'b0;
        end else begin
            lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            // unless stalled, an idle controller stays ready; a busy one takes words
            // at irregular times
            msg_ready_o <= !stall_i
                && (lf[0] || lf[2] || !msg_valid_i);
        end
    end
endmodule

// [ssr_rot_chk.sv]
`timescale 1ns/1ns
module ssr_rot_chk
    import ssr_pkg::*;
#(
    parameter int UPDATE_CYCLES = 200
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // stream and answer
    input wire ssr_word_s msg_word_o,
    input wire logic msg_valid_o,
    input wire logic msg_ready_i,
    input wire logic [1:0] ack_count_o,
    input wire logic [4:0] fp_ind_o
);
    logic [15:0] gap;

    // cycles since the answer last moved; saturates so it never wraps
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || $changed(ack_count_o) || $changed(fp_ind_o)) begin
            gap <= 16'h0;
        end else if (gap != 16'hffff) begin
            gap <= gap + 16'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack lasted more than one cycle");
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("bus ack without a request");
    unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
        !wb_ack_o && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})
        |=> wb_dat_o == 32'h0)
        else $error("unmapped read gave nonzero data");
    ind_legal_a: assert property (fp_ind_o inside {5'h01, 5'h06, 5'h1e})
        else $error("illegal value-kind indication");
    head_hold_a: assert property (msg_valid_o && !msg_ready_i
        |=> msg_valid_o && $stable(msg_word_o))
        else $error("stalled stream word changed");
    answer_spacing_a: assert property ($changed(ack_count_o) || $changed(fp_ind_o)
        |-> gap >= 16'(UPDATE_CYCLES - 4))
        else $error("answer moved between update ticks");
    msg_follows_a: assert property ($changed(ack_count_o) |-> ##[0:60] msg_valid_o)
        else $error("no message after a new answer");

    // main scenarios reached
    cover property (ack_count_o == 2'h2 && fp_ind_o == 5'h06);
    cover property ((msg_valid_o && !msg_ready_i) [*8]);
    cover property (msg_valid_o && msg_ready_i && msg_word_o.last);
endmodule

bind ssr_rotation ssr_rot_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_u (
    .ref_clk_i,
    .rst_n_i,
    .wb_cyc_i,
    .wb_stb_i,
    .wb_we_i,
    .wb_adr_i,
    .wb_dat_o,
    .wb_ack_o,
    .msg_word_o,
    .msg_valid_o,
    .msg_ready_i,
    .ack_count_o,
    .fp_ind_o
);

// [ssr_rotation.sv]
// Behaviour
// (RULE1) controller writes 1 to start rotation
// (RULE2) command 1: ack 1, indication 1, net
// (RULE3) command 2: ack 2, indication 6, rate
// (RULE4) unchanged command word is not a command
// (RULE5) alternate 1/2 advances, wraps to first field
// (RULE6) refresh selected field every 60 ms; a tick that comes while the previous message still drains is skipped
// (RULE7) controller decodes indication before using value
// (RULE8) integer formats are saturated 16-bit signed
// (RULE9) integer in units, division is units/size
// (RULE10) controller multiplies division value by size
// (RULE11) integer formats: 4 bytes each way per slot
// (RULE12) float values are single-precision binary
// (RULE13) float to controller: 8 bytes per slot
// (RULE14) float from controller: 2 + 6 per slot
// (RULE15) exchange organised as 16-bit words
// (RULE16) controller waits for ack before next command
// (RULE17) 3 clears, 41/46 append, indication 30
// (RULE18) command sampled once per update tick
`timescale 1ns/1ns
`include "ssr_defs.svh"
module ssr_rotation
    import ssr_pkg::*;
#(
    parameter int UPDATE_CYCLES = `SSR_UPDATE_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // live measurements in displayed units
    input wire logic signed [31:0] net_weight_i,
    input wire logic signed [31:0] rate_i,
    // message words toward the controller
    output ssr_word_s msg_word_o,
    output logic msg_valid_o,
    input wire logic msg_ready_i,
    // current answer
    output logic [1:0] ack_count_o,
    output logic [4:0] fp_ind_o
);
    ssr_state_s s;
    ssr_state_s next_s;
    ssr_word_s push_word;
    logic push_ready;
    logic tick_hit;
    logic wb_req;

    // merge written byte lanes into an old value
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // clamp to the 16-bit two's-complement range
    function automatic logic [15:0] sat16(input logic signed [31:0] v);
        logic [15:0] r;
        r = v[15:0];
        if (v > `SSR_INT_MAX) begin
            r = 16'h7fff; // RULE8
        end else if (v < `SSR_INT_MIN) begin
            r = 16'h8000; // RULE8
        end
        return r;
    endfunction

    // signed integer to single precision, fraction truncated
    function automatic logic [31:0] to_float(input logic signed [31:0] v);
        logic [31:0] mag;
        logic [31:0] norm;
        logic [7:0] expo;
        int lead;
        mag = v[31] ? 32'(-v) : 32'(v);
        lead = 0;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                lead = i;
            end
        end
        norm = mag << (31 - lead);
        expo = 8'(127 + lead);
        if (mag == 32'h0000_0000) begin
            return 32'h0000_0000;
        end
        return {v[31], expo, norm[30:8]}; // RULE12
    endfunction

    // byte counts per direction for the configured slots
    function automatic logic [15:0] msg_bytes(input ssr_fmt_e fmt,
                                              input logic [1:0] slots);
        logic [7:0] n;
        logic [7:0] to_plc;
        logic [7:0] from_plc;
        n = 8'(slots) + 8'h01;
        if (fmt == SSR_FMT_FLT) begin
            to_plc = 8'(n * `SSR_FLT_IN_SLOT_BYTES); // RULE13
            from_plc = 8'(`SSR_FLT_OUT_OVH_BYTES
                          + n * `SSR_FLT_OUT_SLOT_BYTES); // RULE14
        end else begin
            to_plc = 8'(n * `SSR_INT_SLOT_BYTES); // RULE11
            from_plc = 8'(n * `SSR_INT_SLOT_BYTES); // RULE11
        end
        return {from_plc, to_plc};
    endfunction

    // one word of a slot; float slots hold four, integer slots two
    function automatic ssr_word_s slot_word(input ssr_state_s st);
        ssr_word_s w;
        logic [1:0] last_word;
        last_word = (st.fmt == SSR_FMT_FLT) ? 2'h3 : 2'h1;
        w.last = (st.word == last_word) && (st.slot == st.slots);
        if (st.fmt == SSR_FMT_FLT) begin
            case (st.word)
                2'h0: w.data = {14'h0000, st.ack};
                2'h1: w.data = {11'h000, st.ind};
                2'h2: w.data = st.val[31:16];
                default: w.data = st.val[15:0];
            endcase
        end else begin
            case (st.word)
                2'h0: w.data = st.val[15:0];
                default: w.data = {6'h00, st.ack, 3'h0, st.ind};
            endcase
        end
        return w; // RULE15
    endfunction

    ssr_fifo #(
        .WIDTH($bits(ssr_word_s)),
        .DEPTH(`SSR_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(s.emit == SSR_EM_SEND),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(msg_valid_o),
        .out_ready_i(msg_ready_i),
        .out_data_o(msg_word_o)
    );

    assign push_word = slot_word(s);
    assign tick_hit = (s.tick == 23'(UPDATE_CYCLES - 1));
    assign wb_req = wb_cyc_i && wb_stb_i && !s.wb_ack;
    assign wb_dat_o = s.wb_dat;
    assign wb_ack_o = s.wb_ack;
    assign ack_count_o = s.ack;
    assign fp_ind_o = s.ind;

    // next state: bus, tick, command decode, divider and emitter
    always_comb begin
        logic signed [31:0] sel_val;
        logic [31:0] mag;
        logic [16:0] trial;
        logic [16:0] dsz;
        sel_val = '0;
        mag = '0;
        trial = '0;
        // a zero size would fill the quotient with ones; divide by one
        dsz = (s.div_size == 16'h0000) ? 17'h00001 : {1'b0, s.div_size};
        next_s = s;

        // bus slave, one wait state, unmapped reads return zero
        next_s.wb_ack = wb_req;
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                `SSR_CMD_OFS: begin
                    next_s.cmd_word = 16'(apply_sel({16'h0000, s.cmd_word},
                                                    wb_dat_i, wb_sel_i));
                end
                `SSR_CFG_OFS: begin
                    if (wb_sel_i[0] && wb_dat_i[1:0] != 2'h3) begin
                        next_s.fmt = ssr_fmt_e'(wb_dat_i[1:0]);
                        next_s.slots = wb_dat_i[`SSR_CFG_SLOT_LSB +: 2];
                    end
                end
                `SSR_DIV_OFS: begin
                    next_s.div_size = 16'(apply_sel({16'h0000, s.div_size},
                                                    wb_dat_i, wb_sel_i));
                end
                default: begin
                end
            endcase
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `SSR_CMD_OFS: next_s.wb_dat = {16'h0000, s.cmd_word};
                `SSR_CFG_OFS: next_s.wb_dat = {26'h0, s.slots, 2'h0, s.fmt};
                `SSR_DIV_OFS: next_s.wb_dat = {16'h0000, s.div_size};
                `SSR_STAT_OFS: begin
                    next_s.wb_dat = {s.skipped, 1'b0, s.len, s.ptr,
                                     s.ack, 3'h0, s.ind};
                end
                `SSR_SIZE_OFS: next_s.wb_dat = {16'h0000,
                                                msg_bytes(s.fmt, s.slots)};
                default: next_s.wb_dat = 32'h0000_0000;
            endcase
        end

        // refresh divider, one pulse per update period
        next_s.tick = tick_hit ? 23'h000000 : s.tick + 23'h000001;

        if (tick_hit && s.emit != SSR_EM_IDLE) begin
            // previous message still draining: period is skipped
            next_s.skipped = s.skipped + 16'h0001;
        end
        // the emitter keeps stepping on a skipped tick, since that tick falls to
        // the else branch below, which pushes whenever the buffer has room
        if (tick_hit && s.emit == SSR_EM_IDLE) begin
            // a command is new only if it differs from the last taken
            if (s.cmd_word != s.cmd_last) begin // RULE4 RULE18
                next_s.cmd_last = s.cmd_word;
                case (s.cmd_word)
                    `SSR_CMD_FIRST, `SSR_CMD_NEXT: begin
                        if (!s.started || s.ptr + 3'h1 >= s.len) begin
                            next_s.ptr = 2'h0; // RULE1 RULE5
                        end else begin
                            next_s.ptr = s.ptr + 2'h1; // RULE5
                        end
                        next_s.started = 1'b1;
                        next_s.ack = s.cmd_word[1:0]; // RULE2 RULE3
                    end
                    `SSR_CMD_CLEAR: begin
                        next_s.len = 3'h0; // RULE17
                        next_s.started = 1'b0;
                        next_s.ack = 2'h1;
                    end
                    `SSR_CMD_ADD_NET, `SSR_CMD_ADD_RATE: begin
                        if (s.len < 3'(`SSR_ROT_DEPTH)) begin
                            next_s.rot[s.len[1:0]] =
                                (s.cmd_word == `SSR_CMD_ADD_RATE);
                            next_s.len = s.len + 3'h1; // RULE17
                        end
                        next_s.ack = (s.ack == 2'h3) ? 2'h1 : s.ack + 2'h1;
                    end
                    default: begin
                        next_s.started = 1'b0;
                        next_s.ack = (s.ack == 2'h3) ? 2'h1 : s.ack + 2'h1;
                    end
                endcase
            end

            // pick the field now in force and sample it fresh
            if (next_s.started && next_s.len != 3'h0) begin
                if (next_s.rot[next_s.ptr]) begin
                    next_s.ind = `SSR_IND_RATE; // RULE3
                    sel_val = rate_i;
                end else begin
                    next_s.ind = `SSR_IND_NET; // RULE2
                    sel_val = net_weight_i;
                end
            end else begin
                next_s.ind = `SSR_IND_SETUP; // RULE17
                sel_val = '0;
            end

            // every period not skipped, a new message with fresh data
            next_s.word = 2'h0; // RULE6
            next_s.slot = 2'h0;
            case (s.fmt)
                SSR_FMT_FLT: begin
                    next_s.val = to_float(sel_val); // RULE12
                    next_s.emit = SSR_EM_SEND;
                end
                SSR_FMT_DIV: begin
                    mag = sel_val[31] ? 32'(-sel_val) : 32'(sel_val);
                    next_s.neg = sel_val[31];
                    next_s.quot = mag;
                    next_s.rem = 17'h00000;
                    next_s.dcnt = 6'h00;
                    next_s.emit = SSR_EM_DIV;
                end
                default: begin
                    next_s.val = {16'h0000, sat16(sel_val)}; // RULE9
                    next_s.emit = SSR_EM_SEND;
                end
            endcase
        end else begin
            case (s.emit)
                // restoring divide: one quotient bit per clock
                SSR_EM_DIV: begin
                    trial = {s.rem[15:0], s.quot[31]};
                    next_s.quot = {s.quot[30:0], 1'b0};
                    if (trial >= dsz) begin
                        trial = trial - dsz;
                        next_s.quot[0] = 1'b1;
                    end
                    next_s.rem = trial;
                    next_s.dcnt = s.dcnt + 6'h01;
                    if (s.dcnt == 6'h1f) begin
                        mag = next_s.neg ? 32'(-next_s.quot) : next_s.quot;
                        next_s.val = {16'h0000, sat16(mag)}; // RULE8 RULE9
                        next_s.emit = SSR_EM_SEND;
                    end
                end
                // push words while the buffer has room
                SSR_EM_SEND: begin
                    if (push_ready) begin
                        if (push_word.last) begin
                            next_s.emit = SSR_EM_IDLE;
                        end else if (s.word == ((s.fmt == SSR_FMT_FLT)
                                                ? 2'h3 : 2'h1)) begin
                            next_s.word = 2'h0; // RULE11 RULE13
                            next_s.slot = s.slot + 2'h1;
                        end else begin
                            next_s.word = s.word + 2'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // state register; command history starts at zero so 1 counts as new
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.fmt <= ssr_fmt_e'(`SSR_CFG_RST);
            s.div_size <= `SSR_DIV_RST;
            s.ind <= `SSR_IND_SETUP;
            s.emit <= SSR_EM_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench
    import ssr_pkg::*;
;
    localparam int UPD = 200;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic stall = 1'b0, ack_o, valid, ready;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat_o, seed = 32'h44;
    logic signed [31:0] net = 32'sh0, rate = 32'sh0;
    ssr_word_s word;
    logic [1:0] ackc;
    logic [4:0] ind;
    int n_mismatch = 0, checks_done = 0;
    int m_ack = 0, m_ptr = 0, m_st = 0, fmt = 2, slots = 1, divs = 1;
    int rot[$];
    logic [16:0] expq[$];

    // 125 MHz
    always #4 clk = ~clk;

    ssr_rotation #(.UPDATE_CYCLES(UPD)) dut_u (.ref_clk_i(clk),
        .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat_o),
        .wb_ack_o(ack_o), .net_weight_i(net), .rate_i(rate),
        .msg_word_o(word), .msg_valid_o(valid), .msg_ready_i(ready),
        .ack_count_o(ackc), .fp_ind_o(ind));
    ssr_plc_model pm_u (.ref_clk_i(clk), .rst_n_i(rst_n),
        .msg_valid_i(valid), .stall_i(stall), .msg_ready_o(ready));

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [15:0] sat(int v);
        return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
    endfunction

    task chk(logic [31:0] seen, logic [31:0] e);
        checks_done++;
        if (seen !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one classic cycle; request held until ack is sampled
    task bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 50 && ack_o !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 50) begin
            n_mismatch++;
            report_and_stop();
        end
        r = rdat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // build one message from the model and compare every popped word
    task run_tick;
        int kind, v, i, s, vc;
        logic [31:0] fb;
        logic [63:0] db;
        kind = m_st ? rot[m_ptr] : 30;
        v = kind == 1 ? net : kind == 6 ? rate : 0;
        // inputs fit in 24 bits, so repacking the double is exact
        db = $realtobits($itor(v));
        fb = v == 0 ? 32'h0
            : {db[63], 8'(db[62:52] - 11'h380), db[51:29]};
        if (fmt == 1) v = v / divs;
        vc = 0;
        for (s = 0; s < slots; s++) begin
            if (fmt == 2) begin
                expq.push_back({3'h0, 12'h0, m_ack[1:0]});
                expq.push_back({6'h0, 6'h0, kind[4:0]});
                expq.push_back({1'b0, fb[31:16]});
                expq.push_back({1'b0, fb[15:0]});
            end else begin
                expq.push_back({1'b0, sat(v)});
                expq.push_back({7'h0, m_ack[1:0], 3'h0, kind[4:0]});
            end
        end
        expq[expq.size() - 1][16] = 1'b1;
        for (i = 0; i < 1000 && expq.size() > 0; i++) begin
            @(posedge clk);
            if (valid === 1'b1) vc++;
            if (vc == 40) stall <= 1'b0;
            if (valid === 1'b1 && ready === 1'b1) begin
                chk(word, expq.pop_front());
            end
        end
        if (expq.size() > 0) begin
            n_mismatch++;
            report_and_stop();
        end
        chk(ackc, m_ack);
        chk(ind, kind);
        $display("test done: fmt %0d slots %0d kind %0d", fmt, slots, kind);
    endtask

    // controller writes a command, then waits for its answer
    task cmd(int c);
        wr(8'h00, c);
        if (c == 3) begin
            rot.delete();
            m_ack = 1;
            m_st = 0;
        end else if (c < 3) begin
            m_ptr = m_st ? (m_ptr + 1) % rot.size() : 0;
            m_st = 1;
            m_ack = c;
        end else begin
            if (c inside {41, 46} && rot.size() < 4) begin
                rot.push_back(c == 41 ? 1 : 6);
            end
            m_ack = m_ack == 3 ? 1 : m_ack + 1;
            m_st = 0;
        end
        run_tick();
    endtask

    task rnd;
        net <= (xs() & 32'h3ffff) - 32'h20000;
        rate <= (xs() & 32'h3ffff) - 32'h20000;
        // let the new values land before the model reads them
        @(posedge clk);
    endtask

    initial begin
        logic [31:0] r;
        int f, s;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(ackc, 0);
        chk(ind, 30);
        rnd();
        run_tick();
        cmd(3);
        cmd(41);
        cmd(46);
        cmd(1);
        rnd();
        run_tick();
        cmd(2);
        cmd(1);
        cmd(7);
        cmd(1);
        cmd(2);
        // every format and slot count, largest message of each format stalled
        for (f = 0; f < 3; f++) begin
            for (s = 1; s <= 4; s++) begin
                fmt = f;
                slots = s;
                divs = (xs() & 32'hff) | 1;
                wr(8'h04, {26'h0, 2'(s - 1), 2'h0, 2'(f)});
                wr(8'h08, divs);
                bus(1'b0, 8'h10, 32'h0, r);
                chk(r, f == 2 ? {16'h0, 8'(2 + 6 * s), 8'(8 * s)}
                    : {16'h0, 8'(4 * s), 8'(4 * s)});
                rnd();
                stall <= (s == 4);
                run_tick();
            end
        end
        // refused format code and unmapped place
        wr(8'h04, 32'h3);
        bus(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h32);
        wr(8'h44, 32'hffff);
        bus(1'b0, 8'h40, 32'h0, r);
        chk(r, 32'h0);
        run_tick();
        report_and_stop();
    end

    // watchdog for the whole run
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
